// *** core/arw_consts.svh ***
/*
 * Constants of the word framer: field positions, word and gap lengths,
 * clock and rate figures. Assumes inclusion by bare name, once per file.
 */
`ifndef ARW_CONSTS_SVH
`define ARW_CONSTS_SVH

`define ARW_WORD_BITS   32
`define ARW_LAST_BIT    6'd31
`define ARW_FULL_CNT    6'd32
`define ARW_GAP_BITS    6'd4
`define ARW_LABEL_MSB   7
`define ARW_SRCDST_LSB  8
`define ARW_SRCDST_MSB  9
`define ARW_DATA_LSB    10
`define ARW_DATA_MSB    28
`define ARW_SIGNSTAT_LSB 29
`define ARW_SIGNSTAT_MSB 30
`define ARW_PARITY_BIT  31
`define ARW_SYS_MHZ     9'd125
`define ARW_MHZ_1       8'd1
`define ARW_MHZ_10      8'd10
`define ARW_MHZ_16      8'd16
`define ARW_MHZ_20      8'd20
`define ARW_MULT_12K5   7'd80
`define ARW_MULT_50K    7'd20
`define ARW_MULT_100K   7'd10

`endif

// *** core/arw_pkg.sv ***
/*
 * Types of the word framer: rate and core clock selections, state codes.
 * Assumes the constants header is compiled alongside.
 */
`default_nettype none

package arw_pkg;
   typedef enum logic [1:0] {
      ARW_RATE_12K5 = 2'h0,
      ARW_RATE_50K  = 2'h1,
      ARW_RATE_100K = 2'h2
   } arw_rate_t;

   typedef enum logic [1:0] {
      ARW_CLK_1M  = 2'h0,
      ARW_CLK_10M = 2'h1,
      ARW_CLK_16M = 2'h2,
      ARW_CLK_20M = 2'h3
   } arw_clk_t;

   typedef enum logic [2:0] {
      ARW_TX_IDLE = 3'h1,
      ARW_TX_SEND = 3'h2,
      ARW_TX_GAP  = 3'h4
   } arw_tx_state_t;

   typedef enum logic [1:0] {
      ARW_RX_HUNT    = 2'h1,
      ARW_RX_COLLECT = 2'h2
   } arw_rx_state_t;
endpackage

`default_nettype wire

// *** core/arw_stream_if.sv ***
/*
 * Valid/ready word stream between the framer's own modules.
 * Assumes both ends share one clock.
 */
`default_nettype none

interface arw_stream_if #(parameter int W = 32);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// *** core/arw_buf2.sv ***
/*
 * Two-entry buffer on the transmit word path; ready toward the filler
 * is a flop. Assumes a synchronous active-low reset copy and one clock.
 */
`default_nettype none

module arw_buf2 #(
   parameter int W = 32
) (
   input  wire logic   clk,
   input  wire logic   rst_n,
   arw_stream_if.snk   up,
   arw_stream_if.src   dn
);
   logic [W-1:0] d0;
   logic [W-1:0] d1;
   logic [1:0]   cnt;
   logic [1:0]   next_cnt;
   logic         in_rdy;
   logic         push;
   logic         pop;

   assign push     = up.valid && in_rdy;
   assign pop      = dn.valid && dn.ready;
   assign up.ready = in_rdy;
   assign dn.valid = (cnt != 2'h0);
   assign dn.data  = d0;

   always_comb begin
      next_cnt = cnt;
      if (push && !pop) begin
         next_cnt = cnt + 2'h1;
      end else if (pop && !push) begin
         next_cnt = cnt - 2'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt    <= 2'h0;
         in_rdy <= 1'b0;
      end else begin
         cnt    <= next_cnt;
         // Registered ready from next_cnt: stall reaches the source in the cycle the buffer fills
         in_rdy <= (next_cnt != 2'h2);
      end
   end

   always_ff @(posedge clk) begin
      if (pop) begin
         d0 <= (cnt == 2'h2) ? d1 : up.data;
      end else if (push && cnt == 2'h0) begin
         d0 <= up.data;
      end
      if (push && !pop && cnt == 2'h1) begin
         d1 <= up.data;
      end
   end
endmodule

`default_nettype wire

// *** core/arw_framer.sv ***
/*
 * Word framer: transmit and receive channels for 32-bit words on a
 * one-way bipolar return-to-zero pair. Assumes external line drivers
 * take TX_HI/TX_LO and line receivers deliver RX_HI/RX_LO.
 */
`default_nettype none
`include "arw_consts.svh"

module arw_framer
   import arw_pkg::*;
#(
   parameter int N_TX = 1,
   parameter int N_RX = 1
) (
   input  wire logic              SYS_CLK,
   input  wire logic              RESET_N,
   input  wire logic [1:0]        CLK_SEL,
   input  wire logic [2*N_TX-1:0] TX_RATE,
   input  wire logic [2*N_RX-1:0] RX_RATE,
   input  wire logic [32*N_TX-1:0] TX_DATA,
   input  wire logic [N_TX-1:0]   TX_VALID,
   output logic      [N_TX-1:0]   TX_READY,
   output logic      [N_TX-1:0]   TX_HI,
   output logic      [N_TX-1:0]   TX_LO,
   input  wire logic [N_RX-1:0]   RX_HI,
   input  wire logic [N_RX-1:0]   RX_LO,
   output logic [32*N_RX-1:0]     RX_DATA,
   output logic      [N_RX-1:0]   RX_VALID,
   output logic      [N_RX-1:0]   RX_PAR_ERR,
   output logic      [N_RX-1:0]   RX_FORM_ERR
);
   logic       rst_a;
   logic       rst_n;
   logic [7:0] clk_mhz;
   logic [7:0] acc;
   logic [8:0] acc_sum;
   logic       tick;

   // Mirror of the wire order: bits 8 down to 1 first, then 9 up to 32
   function automatic logic [31:0] arw_order(input logic [31:0] w);
      logic [7:0] lab;
      lab = '0;
      for (int k = 0; k <= `ARW_LABEL_MSB; k++) begin
         lab[k] = w[`ARW_LABEL_MSB - k];
      end
      return {w[`ARW_PARITY_BIT:`ARW_SRCDST_LSB], lab};
   endfunction

   function automatic logic [6:0] arw_mult(input logic [1:0] r);
      logic [6:0] m;
      m = `ARW_MULT_100K;
      unique case (arw_rate_t'(r))
         ARW_RATE_12K5: m = `ARW_MULT_12K5;
         ARW_RATE_50K:  m = `ARW_MULT_50K;
         ARW_RATE_100K: m = `ARW_MULT_100K;
         default:       m = `ARW_MULT_100K;
      endcase
      return m;
   endfunction

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_a <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_a <= 1'b1;
         rst_n <= rst_a;
      end
   end

   always_comb begin
      unique case (arw_clk_t'(CLK_SEL))
         ARW_CLK_1M:  clk_mhz = `ARW_MHZ_1;
         ARW_CLK_10M: clk_mhz = `ARW_MHZ_10;
         ARW_CLK_16M: clk_mhz = `ARW_MHZ_16;
         ARW_CLK_20M: clk_mhz = `ARW_MHZ_20;
      endcase
   end

   assign acc_sum = {1'b0, acc} + {1'b0, clk_mhz};

   // fractional core tick
   // Accumulator keeps the mean tick rate exact despite uneven spacing
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         acc  <= 8'h00;
         tick <= 1'b0;
      end else if (acc_sum >= `ARW_SYS_MHZ) begin
         acc  <= 8'(acc_sum - `ARW_SYS_MHZ);
         tick <= 1'b1;
      end else begin
         acc  <= acc_sum[7:0];
         tick <= 1'b0;
      end
   end

   for (genvar i = 0; i < N_TX; i++) begin : g_tx
      arw_stream_if #(.W(32)) s_in ();
      arw_stream_if #(.W(32)) s_out ();
      arw_tx_state_t state;
      logic [11:0]   tpb;
      logic [10:0]   half;
      logic [10:0]   hcnt;
      logic          phase;
      logic          half_end;
      logic [5:0]    bcnt;
      logic [31:0]   shreg;
      logic [31:0]   word;

      assign s_in.valid  = TX_VALID[i];
      assign s_in.data   = TX_DATA[32*i +: 32];
      assign TX_READY[i] = s_in.ready;
      assign s_out.ready = (state == ARW_TX_IDLE);

      arw_buf2 #(.W(32)) u_buf (
         .clk   (SYS_CLK),
         .rst_n (rst_n),
         .up    (s_in.snk),
         .dn    (s_out.src)
      );

      assign tpb      = 12'(clk_mhz) * 12'(arw_mult(TX_RATE[2*i +: 2]));
      assign half     = tpb[11:1];
      assign half_end = tick && (hcnt == half - 11'h1);

      always_comb begin
         word = s_out.data;
         word[`ARW_PARITY_BIT] = ~^s_out.data[`ARW_PARITY_BIT-1:0];
      end

      always_ff @(posedge SYS_CLK or negedge rst_n) begin
         if (!rst_n) begin
            hcnt  <= 11'h000;
            phase <= 1'b0;
         end else if (state == ARW_TX_IDLE) begin
            hcnt  <= 11'h000;
            phase <= 1'b0;
         end else if (half_end) begin
            hcnt  <= 11'h000;
            phase <= ~phase;
         end else if (tick) begin
            hcnt  <= hcnt + 11'h001;
         end
      end

      always_ff @(posedge SYS_CLK or negedge rst_n) begin
         if (!rst_n) begin
            state <= ARW_TX_IDLE;
            bcnt  <= 6'h00;
            shreg <= 32'h0000_0000;
         end else begin
            unique case (state)
               ARW_TX_IDLE: begin
                  if (s_out.valid) begin
                     shreg <= arw_order(word);
                     bcnt  <= 6'h00;
                     state <= ARW_TX_SEND;
                  end
               end
               ARW_TX_SEND: begin
                  if (half_end && phase) begin
                     shreg <= {1'b0, shreg[31:1]};
                     if (bcnt == `ARW_LAST_BIT) begin
                        bcnt  <= 6'h00;
                        state <= ARW_TX_GAP;
                     end else begin
                        bcnt <= bcnt + 6'h01;
                     end
                  end
               end
               ARW_TX_GAP: begin
                  if (half_end && phase) begin
                     if (bcnt == `ARW_GAP_BITS - 6'h01) begin
                        state <= ARW_TX_IDLE;
                     end else begin
                        bcnt <= bcnt + 6'h01;
                     end
                  end
               end
            endcase
         end
      end

      // word bits or null only
      // Second half of every bit returns to null
      always_ff @(posedge SYS_CLK or negedge rst_n) begin
         if (!rst_n) begin
            TX_HI[i] <= 1'b0;
            TX_LO[i] <= 1'b0;
         end else begin
            TX_HI[i] <= (state == ARW_TX_SEND) && !phase && shreg[0];
            TX_LO[i] <= (state == ARW_TX_SEND) && !phase && !shreg[0];
         end
      end
   end

   for (genvar j = 0; j < N_RX; j++) begin : g_rx
      arw_rx_state_t state;
      logic [1:0]    s1;
      logic [1:0]    s2;
      logic [1:0]    s3;
      logic [1:0]    line;
      logic [1:0]    line_q;
      logic [11:0]   tpb;
      logic [11:0]   ncnt;
      logic          is_null;
      logic          bit_start;
      logic          gap_hit;
      logic [5:0]    bcnt;
      logic          bad;
      logic [31:0]   shreg;
      logic [31:0]   word;

      always_ff @(posedge SYS_CLK or negedge rst_n) begin
         if (!rst_n) begin
            s1 <= 2'h0;
            s2 <= 2'h0;
            s3 <= 2'h0;
         end else begin
            s1 <= {RX_HI[j], RX_LO[j]};
            s2 <= s1;
            s3 <= s2;
         end
      end

      // line state, taken when stages agree
      always_ff @(posedge SYS_CLK or negedge rst_n) begin
         if (!rst_n) begin
            line   <= 2'h0;
            line_q <= 2'h0;
         end else begin
            if (s2 == s3) begin
               line <= s3;
            end
            line_q <= line;
         end
      end

      assign tpb       = 12'(clk_mhz) * 12'(arw_mult(RX_RATE[2*j +: 2]));
      assign is_null   = (line == 2'h0);
      assign bit_start = !is_null && (line_q == 2'h0);
      // One whole bit of null cannot occur inside a word
      assign gap_hit   = tick && is_null && (ncnt == tpb - 12'h001);

      always_ff @(posedge SYS_CLK or negedge rst_n) begin
         if (!rst_n) begin
            ncnt <= 12'h000;
         end else if (!is_null) begin
            ncnt <= 12'h000;
         end else if (tick && ncnt != tpb) begin
            ncnt <= ncnt + 12'h001;
         end
      end

      assign word = arw_order(shreg);

      always_ff @(posedge SYS_CLK or negedge rst_n) begin
         if (!rst_n) begin
            state          <= ARW_RX_HUNT;
            bcnt           <= 6'h00;
            bad            <= 1'b0;
            shreg          <= 32'h0000_0000;
            RX_DATA[32*j +: 32] <= 32'h0000_0000;
            RX_VALID[j]    <= 1'b0;
            RX_PAR_ERR[j]  <= 1'b0;
            RX_FORM_ERR[j] <= 1'b0;
         end else begin
            RX_VALID[j]    <= 1'b0;
            RX_PAR_ERR[j]  <= 1'b0;
            RX_FORM_ERR[j] <= 1'b0;
            unique case (state)
               ARW_RX_HUNT: begin
                  // Start only after a gap so a cut-in word is never framed
                  if (gap_hit) begin
                     bcnt  <= 6'h00;
                     bad   <= 1'b0;
                     state <= ARW_RX_COLLECT;
                  end
               end
               ARW_RX_COLLECT: begin
                  if (bit_start) begin
                     // both rails high is no legal state
                     if (bcnt == `ARW_FULL_CNT || line == 2'h3) begin
                        bad <= 1'b1;
                     end else begin
                        shreg <= {line[1], shreg[31:1]};
                        bcnt  <= bcnt + 6'h01;
                     end
                  end else if (gap_hit && bcnt != 6'h00) begin
                     if (bcnt == `ARW_FULL_CNT && !bad) begin
                        RX_DATA[32*j +: 32] <= word;
                        RX_VALID[j]   <= 1'b1;
                        RX_PAR_ERR[j] <= ~^word;
                     end else begin
                        RX_FORM_ERR[j] <= 1'b1;
                     end
                     bcnt <= 6'h00;
                     bad  <= 1'b0;
                  end
               end
            endcase
         end
      end
   end
endmodule

`default_nettype wire

// *** sim/arw_framer_chk.sv ***
/* Port checker of the word framer, bound to its top.
   Assumes one channel each way. */
`default_nettype none
module arw_framer_chk (
   input wire logic        SYS_CLK,
   input wire logic        RESET_N,
   input wire logic [1:0]  TX_RATE,
   input wire logic [0:0]  TX_HI,
   input wire logic [0:0]  TX_LO,
   input wire logic [31:0] RX_DATA,
   input wire logic [0:0]  RX_VALID,
   input wire logic [0:0]  RX_PAR_ERR,
   input wire logic [0:0]  RX_FORM_ERR
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        any;
   logic        any_q;
   logic        par;
   logic [4:0]  nbit;
   logic [15:0] run;
   int          half;
   assign any  = TX_HI[0] | TX_LO[0];
   assign half = TX_RATE == 2'h0 ? 5000 : TX_RATE == 2'h1 ? 1250 : 625;
   // Saturates, so a long idle never wraps
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         any_q <= 1'b0;
         run   <= 16'hffff;
      end else begin
         any_q <= any;
         run   <= any != any_q ? 16'h1 : run + {15'h0, run != 16'hffff};
      end
   end
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         nbit <= 5'h0;
         par  <= 1'b0;
      end else if (any && !any_q) begin
         nbit <= nbit + 5'h1;
         par  <= nbit == 5'h0 ? TX_HI[0] : par ^ TX_HI[0];
      end
   end
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   property p_rails; !(TX_HI[0] && TX_LO[0]); endproperty
   property p_width; !any && any_q |-> run > half - 9 && run < half + 9; endproperty
   property p_intra; any && !any_q && nbit != 5'h0 |-> run > half - 9 && run < half + 9; endproperty
   property p_gap; any && !any_q && nbit == 5'h0 |-> run > 9 * half - 17; endproperty
   property p_par; any && !any_q && nbit == 5'h1f |-> par ^ TX_HI[0]; endproperty
   property p_pulse; RX_VALID |=> !RX_VALID; endproperty
   property p_perr; RX_PAR_ERR |-> RX_VALID; endproperty
   property p_form; RX_FORM_ERR |-> !RX_VALID; endproperty
   property p_hold; $changed(RX_DATA) |-> RX_VALID; endproperty
   a_rails: assert property (p_rails) else $error("both rails high");
   a_width: assert property (p_width) else $error("pulse width off");
   a_intra: assert property (p_intra) else $error("null inside word off");
   a_gap: assert property (p_gap) else $error("word gap short");
   a_par: assert property (p_par) else $error("sent parity even");
   a_pulse: assert property (p_pulse) else $error("valid too long");
   a_perr: assert property (p_perr) else $error("parity flag alone");
   a_form: assert property (p_form) else $error("bad word delivered");
   a_hold: assert property (p_hold) else $error("data moved");
   c_good: cover property (RX_VALID && !RX_PAR_ERR);
   c_perr: cover property (RX_PAR_ERR);
   c_form: cover property (RX_FORM_ERR);
endmodule
bind arw_framer arw_framer_chk i_arw_framer_chk (.SYS_CLK, .RESET_N, .TX_RATE, .TX_HI, .TX_LO,
   .RX_DATA, .RX_VALID, .RX_PAR_ERR, .RX_FORM_ERR);
`default_nettype wire

// *** sim/arw_line_model.sv ***
/* Line driver and receiver model: logs sent bits, sends words.
   Assumes 100 kbps, a bit time of 1250 clocks. */
`default_nettype none
module arw_line_model (
   input  wire logic clk,
   input  wire logic tx_hi,
   input  wire logic tx_lo,
   output logic      rx_hi,
   output logic      rx_lo
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 625;
   logic prev = 1'b0;
   logic bits [$];
   int   stamp [$];
   int   cyc = 0;
   initial begin
      rx_hi = 1'b0;
      rx_lo = 1'b0;
   end
   always @(posedge clk) begin
      cyc  <= cyc + 1;
      prev <= tx_hi | tx_lo;
      if ((tx_hi | tx_lo) && !prev) begin
         bits.push_back(tx_hi);
         stamp.push_back(cyc);
      end
   end
   task automatic send_word(input logic [31:0] w, input int n);
      int b;
      for (int i = 0; i < n; i++) begin
         b = i < 8 ? 7 - i : i;
         @(posedge clk);
         rx_hi <= w[b];
         rx_lo <= !w[b];
         repeat (HALF) @(posedge clk);
         rx_hi <= 1'b0;
         rx_lo <= 1'b0;
         repeat (HALF - 1) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// *** sim/test_arw_framer.sv ***
/* Bench of the word framer: words out, words in.
   Assumes the line model on both rail pairs. */
`default_nettype none
module test_arw_framer;
   timeunit 1ns;
   timeprecision 1ps;
`define ARW_CHECK(name, exp, got) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
   $display("[ERR] %s expected %h seen %h", name, exp, got); end end
   logic        sys_clk;
   logic        reset_n;
   logic [31:0] tx_data;
   logic [0:0]  tx_valid;
   logic [0:0]  tx_ready;
   logic [0:0]  tx_hi;
   logic [0:0]  tx_lo;
   logic [0:0]  rx_hi;
   logic [0:0]  rx_lo;
   logic [31:0] rx_data;
   logic [0:0]  rx_valid;
   logic [0:0]  rx_par_err;
   logic [0:0]  rx_form_err;
   int          num_errors = 0;
   int          checks_done = 0;
   int          cycles = 0;
   arw_framer i_arw_framer (.SYS_CLK(sys_clk), .RESET_N(reset_n), .CLK_SEL(2'h3), .TX_RATE(2'h2),
      .RX_RATE(2'h2), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_HI(tx_hi),
      .TX_LO(tx_lo), .RX_HI(rx_hi), .RX_LO(rx_lo), .RX_DATA(rx_data), .RX_VALID(rx_valid),
      .RX_PAR_ERR(rx_par_err), .RX_FORM_ERR(rx_form_err));
   arw_line_model i_arw_line_model (.clk(sys_clk), .tx_hi(tx_hi[0]), .tx_lo(tx_lo[0]),
      .rx_hi(rx_hi[0]), .rx_lo(rx_lo[0]));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic test_done();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Two words out and two and a quarter in run about 94000 clocks
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 99000) begin
         num_errors++;
         test_done();
      end
   end
   task automatic rx_word(input logic [31:0] w, input int n, output logic [2:0] got);
      got = 3'h0;
      i_arw_line_model.send_word(w, n);
      for (int k = 0; k < 2500 && got == 3'h0; k++) begin
         @(posedge sys_clk);
         #1;
         got = {rx_valid[0], rx_par_err[0], rx_form_err[0]};
      end
      repeat (100) @(posedge sys_clk);
   endtask
   task automatic test_rx_good();
      logic [31:0] w;
      logic [2:0]  got;
      w = {1'b0, 31'h2a5c_3e81};
      w[31] = ~^w[30:0];
      rx_word(w, 32, got);
      `ARW_CHECK("rx flags", 3'h4, got)
      `ARW_CHECK("rx data", w, rx_data)
   endtask
   task automatic test_rx_parity();
      logic [31:0] w;
      logic [2:0]  got;
      w = {1'b0, 31'h5193_07c4};
      w[31] = ^w[30:0];
      rx_word(w, 32, got);
      `ARW_CHECK("rx flags", 3'h6, got)
      `ARW_CHECK("rx data", w, rx_data)
   endtask
   task automatic test_rx_short();
      logic [2:0] got;
      rx_word(32'h0000_ffff, 8, got);
      `ARW_CHECK("rx flags", 3'h1, got)
   endtask
   task automatic test_tx();
      logic [31:0] w [3];
      logic [31:0] got;
      logic [31:0] exp_w;
      int          k;
      int          gap;
      w = '{32'h8012_34a5, 32'h7fed_cb5a, 32'h0000_0301};
      for (int n = 0; n < 3; n++) begin
         tx_data  <= w[n];
         tx_valid <= 1'b1;
         k = 0;
         do begin
            @(posedge sys_clk);
            k++;
         end while (tx_ready !== 1'b1 && k < 50);
      end
      tx_valid <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      `ARW_CHECK("tx ready full", 1'b0, tx_ready)
      k = 0;
      while (i_arw_line_model.bits.size() < 65 && k < 100000) begin
         @(posedge sys_clk);
         k++;
      end
      for (int n = 0; n < 2; n++) begin
         for (int i = 0; i < 32; i++) begin
            got[i < 8 ? 7 - i : i] = i_arw_line_model.bits[32 * n + i];
         end
         exp_w = {~^w[n][30:0], w[n][30:0]};
         `ARW_CHECK("tx word", exp_w, got)
         gap = i_arw_line_model.stamp[32 * n + 32] - i_arw_line_model.stamp[32 * n + 31];
         `ARW_CHECK("tx gap", 1'b1, gap > 6234 && gap < 6266)
      end
   endtask
   initial begin
      reset_n  = 1'b0;
      tx_data  = 32'h0;
      tx_valid = 1'b0;
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (1300) @(posedge sys_clk);
      fork
         test_tx();
         begin
            test_rx_good();
            test_rx_parity();
            test_rx_short();
         end
      join
      test_done();
   end
endmodule
`default_nettype wire
